// ### hdl/pll_ctl.sv
// pll control: dividers, phase and delay settings, reference switchover
// Function
// [RQ1] one pre-scale and one multiply counter, 1..512
// [RQ2] oscillator = input * multiply / pre-scale
// [RQ3] each output has its own post-scale counter
// [RQ4] two regional, four global, four external counters
// [RQ5] 50% duty post-scale range is 1..1024
// [RQ6] other duty cycles limit range to 1..512
// [RQ7] phase step is oscillator period over eight
// [RQ8] phase steps of at most 45 degrees
// [RQ9] delay shift in 250 ps steps, +-3 ns
// [RQ10] auto mode leaves primary when it stops
// [RQ11] auto sensing only for references within 20%
// [RQ12] switch request input changes reference selection
// [RQ13] user drives switch request from lock indication
// [RQ14] reference change makes no glitch or runt
// [RQ15] oscillator keeps running during reference change
// [RQ16] relock on new reference within 100 us
// [RQ17] lock drops during switchover, returns when settled
// [RQ18] after auto switch stay on secondary
`timescale 1ns/10ps
module pll_ctl import pll_ctl_pkg::*; #(
  parameter int RELOCK_CYCLES = RELOCK_CYCLES_DEF
) (
  input wire logic clk, // 200 MHz system clock
  input wire logic rst, // asynchronous reset, active high
  input wire logic primary_ref_input, // primary reference
  input wire logic secondary_ref_input, // secondary reference
  input wire logic switch_req, // rising edge requests a reference change
  input wire av_req_t av_req, // avalon-mm request
  output logic [31:0] av_readdata, // avalon-mm read data
  output logic av_waitrequest, // avalon-mm wait request
  output logic [NOUT-1:0] clk_out, // regional 0..1, global 2..5, external 6..9
  output logic [NOUT-1:0][4:0] dly_code, // signed delay step per output
  output logic ref_clk_out, // gated selected reference
  output logic ref_sel, // 1 = secondary selected
  output logic locked, // loop locked
  output logic irq // level interrupt
);
  state_t s, n;
  logic pri_alive, sec_alive, cur_in, cur_alive, man_edge, auto_go;
  logic redge, inj, sub;
  logic [16:0] cr;
  logic [NEV-1:0] ev;
  logic wr;
  logic [3:0] pidx;
  logic in_post;
  logic [31:0] rd;
  logic [13:0] per8, sft, hi8, cnt;
  post_t pw;

  always_comb begin
    n = s;
    ev = '0;
    inj = 1'b0;
    sub = 1'b0;
    cr = '0;
    per8 = '0;
    sft = '0;
    hi8 = '0;
    cnt = '0;
    rd = '0;
    pw = '0;
    n.pri_q = primary_ref_input;
    n.sec_q = secondary_ref_input;
    n.man_q = switch_req;
    man_edge = switch_req & ~s.man_q;
    pri_alive = s.pri_miss < 8'(LOSS_CYCLES);
    sec_alive = s.sec_miss < 8'(LOSS_CYCLES);
    if (primary_ref_input != s.pri_q) begin
      n.pri_miss = '0;
    end else if (pri_alive) begin
      n.pri_miss = s.pri_miss + 8'h01;
    end
    if (secondary_ref_input != s.sec_q) begin
      n.sec_miss = '0;
    end else if (sec_alive) begin
      n.sec_miss = s.sec_miss + 8'h01;
    end
    cur_in = s.sel ? secondary_ref_input : primary_ref_input;
    cur_alive = s.sel ? sec_alive : pri_alive;
    // only toggling is sensed; frequencies are never compared
    // auto never fires while the secondary is selected
    auto_go = s.auto_en & ~s.sel & ~pri_alive; // [RQ10] [RQ11] [RQ18]

    // switchover: gate old reference while low, ungate new while low
    case (s.fsm)
      SW_RUN: begin
        n.gate = 1'b1;
        if (man_edge || auto_go) begin // [RQ12]
          n.fsm = SW_OLD;
          ev[EV_AUTO] = auto_go & ~man_edge;
        end
      end
      SW_OLD: begin
        if (!cur_in || !cur_alive) begin // [RQ14]
          n.sel = ~s.sel;
          n.gate = 1'b0;
          n.fsm = SW_NEW;
        end
      end
      SW_NEW: begin
        if (!cur_in || !cur_alive) begin // [RQ14]
          n.gate = 1'b1;
          n.fsm = SW_RUN;
        end
      end
      default: begin
        n.fsm = SW_RUN;
      end
    endcase
    n.ref_out = n.gate & (n.sel ? secondary_ref_input : primary_ref_input);

    // oscillator model: eight sub-ticks per period, credit m*8 per reference
    // edge and spend n per sub-tick
    redge = n.ref_out & ~s.ref_out;
    if (s.tmr != 16'hffff) begin
      n.tmr = s.tmr + 16'h0001;
    end
    if (redge) begin
      n.per = s.tmr;
      n.tmr = '0;
      inj = 1'b1;
    end else if (s.per != 16'h0000 && s.tmr >= s.per) begin
      // no edge while switching: keep running on the last period
      n.tmr = '0;
      inj = 1'b1; // [RQ15]
    end
    cr = {1'b0, s.credit} + (inj ? {4'h0, s.mul, 3'b000} : 17'h0_0000); // [RQ2]
    if (cr >= {7'h00, s.pre}) begin // [RQ2]
      sub = 1'b1;
      cr = cr - {7'h00, s.pre};
    end
    n.credit = cr[16] ? 16'hffff : cr[15:0];

    // one independent post-scale counter per output
    for (int i = 0; i < NOUT; i++) begin // [RQ3] [RQ4]
      per8 = {s.post[i].div, 3'b000};
      cnt = s.pcnt[i];
      if (cnt >= per8) begin
        cnt = '0;
      end else if (sub) begin
        cnt = (cnt == per8 - 14'h0001) ? 14'h0000 : cnt + 14'h0001;
      end
      n.pcnt[i] = cnt;
      // phase offset in sub-ticks, one eighth of the oscillator period each
      if (cnt >= {11'h000, s.post[i].ph}) begin // [RQ7] [RQ8]
        sft = cnt - {11'h000, s.post[i].ph};
      end else begin
        sft = cnt + per8 - {11'h000, s.post[i].ph};
      end
      hi8 = s.post[i].duty50 ? {1'b0, s.post[i].div, 2'b00} : {1'b0, s.post[i].hi, 3'b000};
      n.cko[i] = sft < hi8;
    end

    // lock tracking
    if (s.fsm != SW_RUN || !cur_alive) begin
      n.locked = 1'b0; // [RQ17]
      n.lock_cnt = '0;
    end else if (!s.locked) begin
      if (s.lock_cnt >= 20'(RELOCK_CYCLES - 1)) begin
        n.locked = 1'b1; // [RQ16] [RQ17]
      end else begin
        n.lock_cnt = s.lock_cnt + 20'h0_0001;
      end
    end
    ev[EV_LOST] = s.locked & ~n.locked;
    ev[EV_LOCK] = ~s.locked & n.locked;

    // register bus: one wait cycle, then the access completes
    n.ack = (av_req.read | av_req.write) & ~s.ack;
    wr = av_req.write & s.ack;
    in_post = av_req.address >= A_POST && av_req.address < A_POST + 8'(4 * NOUT)
      && av_req.address[1:0] == 2'b00;
    pidx = 4'((av_req.address - A_POST) >> 2);
    case (av_req.address)
      A_CTRL: rd = {31'h0000_0000, s.auto_en};
      A_STAT: rd = {27'h000_0000, (s.fsm != SW_RUN), sec_alive, pri_alive, s.locked, s.sel};
      A_PRE: rd = {22'h00_0000, s.pre};
      A_MUL: rd = {22'h00_0000, s.mul};
      A_IRQ_ST: rd = {28'h000_0000, s.irq_st};
      A_IRQ_EN: rd = {28'h000_0000, s.irq_en};
      default: rd = in_post ? {2'b00, s.post[pidx]} : 32'h0000_0000;
    endcase
    if (av_req.read && !s.ack) begin
      n.rdata = rd;
    end
    pw = av_req.writedata[29:0];
    if (wr) begin
      case (av_req.address)
        A_CTRL: n.auto_en = av_req.writedata[0];
        A_PRE: begin
          if (nm_ok(av_req.writedata)) begin // [RQ1]
            n.pre = av_req.writedata[9:0];
          end else begin
            ev[EV_ERR] = 1'b1;
          end
        end
        A_MUL: begin
          if (nm_ok(av_req.writedata)) begin // [RQ1]
            n.mul = av_req.writedata[9:0];
          end else begin
            ev[EV_ERR] = 1'b1;
          end
        end
        A_IRQ_CLR: n.irq_st = s.irq_st & ~av_req.writedata[NEV-1:0];
        A_IRQ_EN: n.irq_en = av_req.writedata[NEV-1:0];
        default: begin
          if (in_post) begin
            if (post_ok(pw)) begin // [RQ5] [RQ6] [RQ9]
              n.post[pidx] = pw;
            end else begin
              ev[EV_ERR] = 1'b1;
            end
          end
        end
      endcase
    end
    // a new event wins over a clear in the same cycle
    n.irq_st = n.irq_st | ev;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.fsm <= SW_RUN;
      s.gate <= 1'b1;
      s.auto_en <= AUTO_RST;
      s.pre <= NM_RST;
      s.mul <= NM_RST;
      for (int i = 0; i < NOUT; i++) begin
        s.post[i].div <= DIV_RST;
        s.post[i].duty50 <= 1'b1;
      end
    end else begin
      s <= n;
    end
  end

  assign av_waitrequest = (av_req.read | av_req.write) & ~s.ack;
  assign av_readdata = s.rdata;
  assign clk_out = s.cko;
  assign ref_clk_out = s.ref_out;
  assign ref_sel = s.sel;
  assign locked = s.locked;
  assign irq = |(s.irq_st & s.irq_en);

  generate
    for (genvar g = 0; g < NOUT; g++) begin : g_dly
      assign dly_code[g] = s.post[g].dly; // [RQ9]
    end
  endgenerate

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_switch_start;
    s.fsm == SW_RUN && (man_edge || auto_go);
  endsequence

  sequence s_auto_only;
    s.fsm == SW_RUN && auto_go && !man_edge;
  endsequence

  property p_auto_switch;
    s_auto_only |=> s.fsm == SW_OLD ##0 s.irq_st[EV_AUTO];
  endproperty
  a_auto_switch: assert property (p_auto_switch) else $error("auto switch not started"); // [RQ10]

  property p_sticky_sec;
    (s.sel && s.fsm == SW_RUN && !man_edge) |=> s.sel;
  endproperty
  a_sticky_sec: assert property (p_sticky_sec) else $error("secondary left without request"); // [RQ18]

  property p_no_runt;
    $changed(s.sel) |-> !s.ref_out && !s.gate ##1 !s.ref_out || s.fsm == SW_RUN;
  endproperty
  a_no_runt: assert property (p_no_runt) else $error("reference glitch on switch"); // [RQ14]

  property p_lock_drop;
    // locked is registered from the first switching cycle, so it falls one edge later
    s_switch_start |-> ##2 !s.locked [*2];
  endproperty
  a_lock_drop: assert property (p_lock_drop) else $error("lock held during switch"); // [RQ17]

  property p_relock;
    (s.fsm == SW_RUN && cur_alive && !s.locked && !man_edge && !auto_go
      && s.lock_cnt == 20'(RELOCK_CYCLES - 1)) |=> s.locked;
  endproperty
  a_relock: assert property (p_relock) else $error("relock late"); // [RQ16]

  property p_nm_range;
    s.pre >= 10'h001 && s.pre <= 10'(NM_MAX) && s.mul >= 10'h001 && s.mul <= 10'(NM_MAX);
  endproperty
  a_nm_range: assert property (p_nm_range) else $error("pre-scale or multiply out of range"); // [RQ1]

  property p_post50;
    s.post[0].duty50 |-> s.post[0].div >= 11'h001 && s.post[0].div <= 11'(POST_MAX50);
  endproperty
  a_post50: assert property (p_post50) else $error("post divide over 1024"); // [RQ5]

  property p_post_nd;
    !s.post[0].duty50 |-> s.post[0].div <= 11'(POST_MAX);
  endproperty
  a_post_nd: assert property (p_post_nd) else $error("post divide over 512"); // [RQ6]

  // the port is plain bits; compare it as a signed step count
  property p_dly;
    $signed(dly_code[0]) >= -$signed(5'(DLY_MAX))
      && $signed(dly_code[0]) <= $signed(5'(DLY_MAX));
  endproperty
  a_dly: assert property (p_dly) else $error("delay code out of span"); // [RQ9]

  // switchover steps: old input seen low, then new input seen low
  sequence s_old_done;
    s.fsm == SW_OLD && (!cur_in || !cur_alive);
  endsequence

  sequence s_new_done;
    s.fsm == SW_NEW && (!cur_in || !cur_alive);
  endsequence

  property p_old_close;
    s_old_done |=> $changed(s.sel) && !s.gate && !s.ref_out && s.fsm == SW_NEW;
  endproperty
  a_old_close: assert property (p_old_close) else $error("old reference not closed low"); // [RQ14]

  property p_new_low;
    s_new_done |=> s.gate && !s.ref_out && s.fsm == SW_RUN;
  endproperty
  a_new_low: assert property (p_new_low) else $error("new reference opened high"); // [RQ14]

  property p_new_wait;
    s.fsm == SW_NEW && cur_in && cur_alive |=> !s.gate && !s.ref_out && s.fsm == SW_NEW;
  endproperty
  a_new_wait: assert property (p_new_wait) else $error("gate opened too early"); // [RQ14]

  // with no reference edge the model keeps ticking on the last period
  property p_osc_free;
    s.per != 16'h0000 && s.tmr >= s.per |=> s.tmr == 16'h0000;
  endproperty
  a_osc_free: assert property (p_osc_free) else $error("oscillator stopped"); // [RQ15]

  property p_lock_run;
    s.fsm != SW_RUN |=> !s.locked;
  endproperty
  a_lock_run: assert property (p_lock_run) else $error("locked while switching"); // [RQ17]

  // refused values leave the counters untouched and flag the bad write
  property p_pre_keep;
    wr && av_req.address == A_PRE && !nm_ok(av_req.writedata) |=> $stable(s.pre);
  endproperty
  a_pre_keep: assert property (p_pre_keep) else $error("bad pre-scale accepted"); // [RQ1]

  property p_mul_keep;
    wr && av_req.address == A_MUL && !nm_ok(av_req.writedata) |=> $stable(s.mul);
  endproperty
  a_mul_keep: assert property (p_mul_keep) else $error("bad multiply accepted"); // [RQ1]

  property p_post_keep;
    wr && in_post && !post_ok(pw) |=> $stable(s.post);
  endproperty
  a_post_keep: assert property (p_post_keep) else $error("bad post setting accepted"); // [RQ5] [RQ6] [RQ9]

  property p_err_flag;
    wr && av_req.address == A_PRE && !nm_ok(av_req.writedata) |=> s.irq_st[EV_ERR];
  endproperty
  a_err_flag: assert property (p_err_flag) else $error("bad write not flagged"); // [RQ1]

  // once on the secondary, only a user request starts another switch
  property p_auto_once;
    s.fsm == SW_RUN && s.sel && !man_edge |=> s.fsm == SW_RUN;
  endproperty
  a_auto_once: assert property (p_auto_once) else $error("switch back without request"); // [RQ18]
endmodule : pll_ctl

// ### hdl/pll_ctl_pkg.sv
// package: constants, register map and types of the pll control block
package pll_ctl_pkg;
  // output layout: regional, then global, then external post-scale counters
  localparam int NREG = 2;
  localparam int NGLB = 4;
  localparam int NEXT = 4;
  localparam int NOUT = NREG + NGLB + NEXT;
  localparam int CLK_PERIOD_NS = 5;
  localparam int RELOCK_US = 100;
  localparam int RELOCK_CYCLES_DEF = RELOCK_US * 1000 / CLK_PERIOD_NS;
  localparam int LOSS_TIME_NS = 320;
  localparam int LOSS_CYCLES = (LOSS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PHASE_TAPS = 8;
  localparam int DLY_STEP_PS = 250;
  localparam int DLY_SPAN_PS = 3000;
  localparam int DLY_MAX = DLY_SPAN_PS / DLY_STEP_PS;
  localparam int NM_MAX = 512;
  localparam int POST_MAX50 = 1024;
  localparam int POST_MAX = 512;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_PRE = 8'h08;
  localparam logic [7:0] A_MUL = 8'h0c;
  localparam logic [7:0] A_IRQ_ST = 8'h10;
  localparam logic [7:0] A_IRQ_CLR = 8'h14;
  localparam logic [7:0] A_IRQ_EN = 8'h18;
  localparam logic [7:0] A_POST = 8'h20;
  localparam int EV_LOST = 0;
  localparam int EV_LOCK = 1;
  localparam int EV_AUTO = 2;
  localparam int EV_ERR = 3;
  localparam int NEV = 4;
  localparam logic [9:0] NM_RST = 10'h001;
  localparam logic [10:0] DIV_RST = 11'h001;
  localparam logic AUTO_RST = 1'b1;

  typedef enum logic [1:0] {SW_RUN, SW_OLD, SW_NEW} sw_st_t;

  typedef struct packed {
    logic [9:0] hi;
    logic signed [4:0] dly;
    logic [2:0] ph;
    logic duty50;
    logic [10:0] div;
  } post_t;

  typedef struct packed {
    logic [7:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } av_req_t;

  typedef struct packed {
    sw_st_t fsm;
    logic sel;
    logic gate;
    logic ref_out;
    logic pri_q;
    logic sec_q;
    logic man_q;
    logic [7:0] pri_miss;
    logic [7:0] sec_miss;
    logic auto_en;
    logic [9:0] pre;
    logic [9:0] mul;
    logic [15:0] credit;
    logic [15:0] per;
    logic [15:0] tmr;
    logic [19:0] lock_cnt;
    logic locked;
    logic [NEV-1:0] irq_st;
    logic [NEV-1:0] irq_en;
    logic ack;
    logic [31:0] rdata;
    post_t [NOUT-1:0] post;
    logic [NOUT-1:0][13:0] pcnt;
    logic [NOUT-1:0] cko;
  } state_t;

  function automatic logic nm_ok(input logic [31:0] v);
    return v >= 32'h0000_0001 && v <= 32'(NM_MAX);
  endfunction : nm_ok

  function automatic logic post_ok(input post_t p);
    logic lim;
    lim = p.duty50 ? (p.div <= 11'(POST_MAX50)) : (p.div <= 11'(POST_MAX));
    return p.div != 11'h000 && lim && p.dly >= -$signed(5'(DLY_MAX))
      && p.dly <= $signed(5'(DLY_MAX))
      && (p.duty50 || (p.hi != 10'h000 && {1'b0, p.hi} < p.div));
  endfunction : post_ok
endpackage : pll_ctl_pkg

// ### dv/ref_src.sv
// reference clock sources on the far side of the pll control block
`timescale 1ns/10ps
module ref_src #(
  parameter int HALF_P = 16,
  parameter int HALF_S = 14
) (
  input wire logic clk, // system clock
  input wire logic rst, // asynchronous reset
  input wire logic pri_run, // primary keeps toggling
  input wire logic sec_run, // secondary keeps toggling
  output logic pri, // primary reference level
  output logic sec // secondary reference level
);
  int pc;
  int sc;
  // periods 32 and 28 cycles stay within 20 percent of each other
  // a stopped source ends its high phase, then stands low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pc <= 0;
      sc <= 0;
      pri <= 1'b0;
      sec <= 1'b0;
    end else begin
      pc <= (pc == HALF_P - 1) ? 0 : pc + 1;
      sc <= (sc == HALF_S - 1) ? 0 : sc + 1;
      if (pc == HALF_P - 1 && (pri_run || pri)) begin
        pri <= !pri;
      end
      if (sc == HALF_S - 1 && (sec_run || sec)) begin
        sec <= !sec;
      end
    end
  end
endmodule : ref_src

// ### dv/tb.sv
// self-checking testbench of the pll control block
`timescale 1ns/10ps
module tb;
  import pll_ctl_pkg::*;
  localparam int RLK = 200;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic pri, sec, pri_run, sec_run, switch_req;
  av_req_t av_req;
  logic [31:0] av_readdata, q;
  logic av_waitrequest, ref_clk_out, ref_sel, locked, irq;
  logic [NOUT-1:0] clk_out, prev_o;
  logic [NOUT-1:0][4:0] dly_code;
  int errors, checked, n, cyc, tog, hi_n, t0;
  int per_q [NOUT];
  int last_r [NOUT];

  always #2.5 clk = ~clk;

  ref_src SRC (.clk(clk), .rst(rst), .pri_run(pri_run), .sec_run(sec_run), .pri(pri),
    .sec(sec));
  pll_ctl #(.RELOCK_CYCLES(RLK)) DUT (.clk(clk), .rst(rst), .primary_ref_input(pri),
    .secondary_ref_input(sec), .switch_req(switch_req), .av_req(av_req),
    .av_readdata(av_readdata), .av_waitrequest(av_waitrequest), .clk_out(clk_out),
    .dly_code(dly_code), .ref_clk_out(ref_clk_out), .ref_sel(ref_sel), .locked(locked),
    .irq(irq));

  // output periods, toggles of output 0 and high pulses of the selected reference
  always @(posedge clk) begin
    cyc++;
    for (int i = 0; i < NOUT; i++) begin
      if (clk_out[i] === 1'b1 && prev_o[i] === 1'b0) begin
        per_q[i] = cyc - last_r[i];
        last_r[i] = cyc;
      end
    end
    if (clk_out[0] !== prev_o[0]) tog++;
    prev_o = clk_out;
    if (ref_clk_out === 1'b1) hi_n++;
    else begin
      if (hi_n != 0 && hi_n < 14) begin
        errors++;
        $display("BAD %0t runt on selected reference", $time);
      end
      hi_n = 0;
    end
  end

  task automatic summarize;
    if (errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d,
    output logic [31:0] rq);
    int k;
    @(posedge clk);
    av_req <= '{address: a, read: !wr, write: wr, writedata: d};
    k = 0;
    // waitrequest and read data are taken at the rising edge that ends the access
    do begin
      @(posedge clk);
      k++;
    end while (av_waitrequest !== 1'b0 && k < 100);
    rq = av_readdata;
    av_req <= '0;
    chk(32'(k < 100), 1, "bus hang");
  endtask : bus

  task automatic wait_for(input int w, input logic v, input int lim, output int c);
    c = 0;
    while ((w == 0 ? locked : ref_sel) !== v && c < lim) begin
      @(negedge clk);
      c++;
    end
  endtask : wait_for

  task automatic t_reset;
    bus(A_PRE, 0, 0, q);
    chk(q, 32'h0000_0001, "pre reset");
    bus(A_MUL, 0, 0, q);
    chk(q, 32'h0000_0001, "mul reset");
    for (int i = 0; i < NOUT; i++) begin
      bus(A_POST + 8'(4 * i), 0, 0, q);
      chk(q, 32'h0000_0801, "post reset");
    end
    bus(A_CTRL, 0, 0, q);
    chk(q, 32'h0000_0001, "ctrl reset");
    bus(A_IRQ_EN, 0, 0, q);
    chk(q, 32'h0000_0000, "irq en reset");
    bus(8'hfc, 1, 32'hffff_ffff, q);
    bus(8'hfc, 0, 0, q);
    chk(q, 32'h0000_0000, "unmapped");
  endtask : t_reset

  task automatic t_range;
    logic [7:0] ta [13] = '{A_PRE, A_PRE, A_PRE, A_MUL, A_MUL, A_POST, A_POST, A_POST,
      A_POST, A_POST, A_POST, A_POST, A_MUL};
    logic [31:0] td [13] = '{32'h0000_0200, 32'h0000_0201, 32'h0000_0000, 32'h0000_0200,
      32'h0000_0201, 32'h0000_0c00, 32'h0000_0c01, 32'h1000_0200, 32'h1000_0201,
      32'h0006_0801, 32'h0006_8801, 32'h000a_7801, 32'h0000_0000};
    logic [31:0] te [13] = '{32'h0000_0200, 32'h0000_0200, 32'h0000_0200, 32'h0000_0200,
      32'h0000_0200, 32'h0000_0c00, 32'h0000_0c00, 32'h1000_0200, 32'h1000_0200,
      32'h0006_0801, 32'h0006_0801, 32'h000a_7801, 32'h0000_0200};
    for (int i = 0; i < 13; i++) begin
      bus(ta[i], 1, td[i], q);
      bus(ta[i], 0, 0, q);
      chk(q, te[i], "range");
    end
    chk(32'(dly_code[0]), 32'h0000_0014, "delay code");
  endtask : t_range

  task automatic t_irq;
    bus(A_IRQ_ST, 0, 0, q);
    chk(q & 32'h8, 32'h8, "bad write flag");
    @(negedge clk);
    chk(32'(irq), 0, "irq masked");
    bus(A_IRQ_EN, 1, 32'h0000_0008, q);
    @(negedge clk);
    chk(32'(irq), 1, "irq enabled");
    bus(A_IRQ_CLR, 1, 32'h0000_0008, q);
    @(negedge clk);
    chk(32'(irq), 0, "irq cleared");
    bus(A_IRQ_ST, 0, 0, q);
    chk(q & 32'h8, 32'h0, "flag cleared");
  endtask : t_irq

  task automatic t_switch(input logic to);
    @(posedge clk);
    switch_req <= 1'b1;
    t0 = tog;
    wait_for(0, 1'b0, 4, n);
    chk(32'(n < 4), 1, "lock kept");
    wait_for(1, to, 300, n);
    chk(32'(ref_sel), 32'(to), "no switch");
    wait_for(0, 1'b1, RLK + 300, n);
    chk(32'(locked), 1, "no relock");
    chk(32'(tog != t0), 1, "outputs stopped");
    bus(A_IRQ_ST, 0, 0, q);
    switch_req <= 1'b0;
    chk(q & 32'h3, 32'h3, "lock events");
    bus(A_IRQ_CLR, 1, 32'h0000_0003, q);
  endtask : t_switch

  // primary period is 32 cycles; 8*mul/pre = 32 sub-ticks per period gives one
  // sub-tick a cycle, so an output of divide d repeats every 8*d cycles
  task automatic t_freq;
    bus(A_PRE, 1, 32'h0000_0002, q);
    bus(A_MUL, 1, 32'h0000_0008, q);
    for (int i = 0; i < NOUT; i++) bus(A_POST + 8'(4 * i), 1, 32'h0000_0801 + 32'(i), q);
    repeat (700) @(negedge clk);
    for (int i = 0; i < NOUT; i++) begin
      chk(32'(per_q[i]), 32'(8 * (i + 1)), "period");
    end
  endtask : t_freq

  task automatic t_auto;
    @(posedge clk);
    pri_run <= 1'b0;
    wait_for(1, 1'b1, 200, n);
    chk(32'(ref_sel), 1, "no auto switch");
    bus(A_IRQ_ST, 0, 0, q);
    pri_run <= 1'b1;
    chk(q & 32'h4, 32'h4, "auto event");
    repeat (400) @(negedge clk);
    chk(32'(ref_sel), 1, "left secondary");
  endtask : t_auto

  initial begin
    av_req = '0;
    switch_req = 1'b0;
    pri_run = 1'b1;
    sec_run = 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_range();
    t_irq();
    wait_for(0, 1'b1, 4000, n);
    chk(32'(locked), 1, "no first lock");
    t_switch(1'b1);
    t_switch(1'b0);
    t_freq();
    t_auto();
    summarize();
  end

  initial begin
    #200_000;
    errors++;
    summarize();
  end
endmodule : tb
